// ===== verilog/alu_core.sv
`timescale 1ns/100ps

// Notes on behaviour
// [RULE1] Set-carry sets carry, keeps other flags; opcode DF, four cycles.
// [RULE2] Arithmetic right shift moves bits down, bit seven kept and copied.
// [RULE3] Shift: carry gets old bit zero, Z/S from result, V cleared.
// [RULE4] Stop halts CPU and system clocks, enters stop mode, no flags change.
// [RULE5] In stop mode register contents stay as they were.
// [RULE6] Stop mode ends only by external reset or external interrupt.
// [RULE7] Outside party holds reset low until the oscillator has settled.
// [RULE8] Subtract stores destination minus source, source left unchanged.
// [RULE9] Subtract: carry is borrow, Z/S from result, V per sign test.
// [RULE10] Subtract sets D; H is set on low-nibble borrow, else cleared.
// [RULE11] Mask test computes (not dst) and src, for flags only.
// [RULE12] Mask test: Z/S from result, V cleared, C/D/H kept.
// [RULE13] Result and flags are written together at completion.

module alu_core
	import alu_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Wake-up pin, active low
	input wire logic ext_int_n,
	// Clock control towards the clock circuit
	output logic cpu_clk_en,
	output logic sys_clk_en,
	output logic stop_mode
);
	import alu_pkg::*;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	alu_state_t state_reg;
	logic [7:0] op_reg;
	logic [7:0] dst_reg;
	logic [7:0] src_reg;
	logic [7:0] flags_reg;
	logic [2:0] cnt_reg;
	logic err_reg;
	logic int_n_sync;
	logic acc;
	logic apb_wr;
	logic addr_ok;
	logic idle;
	logic wr_ctrl;
	logic legal;
	logic start;
	logic done;
	logic is_shift;
	logic is_sub;
	logic is_mask;
	logic [2:0] cycles;
	logic [8:0] sub_sum;
	logic [4:0] nib_sum;
	logic [7:0] res;
	logic [7:0] flags_next;
	logic dst_wr;

	// Wake-up pin passes two flops before any logic reads it
	alu_sync2 #(
		.RST_VAL(EXT_INT_N_RST)
	) u_int_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(ext_int_n),
		.sync_out(int_n_sync)
	);

	// Bus decode
	assign acc = psel && penable;
	assign apb_wr = acc && pwrite;
	assign idle = (state_reg == ST_IDLE);
	assign addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_DST) ||
		(paddr == OFS_SRC) || (paddr == OFS_FLAGS) ||
		(paddr == OFS_STATUS);
	assign pready = 1'b1;
	// Writes while busy or stopped are refused so state is retained
	assign pslverr = acc && (!addr_ok || (pwrite && (!idle ||
		paddr == OFS_STATUS))); // see [RULE5]

	assign wr_ctrl = apb_wr && idle && (paddr == OFS_CTRL);

	// Opcode classes
	always_comb begin
		is_shift = (op_reg == OP_SHIFT_R) || (op_reg == OP_SHIFT_IR);
		is_sub = (op_reg >= OP_SUB_FIRST) && (op_reg <= OP_SUB_LAST);
		is_mask = (op_reg >= OP_MASK_FIRST) && (op_reg <= OP_MASK_LAST);
	end

	// Decode of a requested opcode and its length
	always_comb begin
		legal = 1'b0;
		cycles = CYC_LONG;
		case (pwdata[7:0])
			OP_SET_CARRY, OP_SHIFT_R, OP_SHIFT_IR, OP_STOP: begin
				legal = 1'b1;
				cycles = CYC_SHORT; // see [RULE1]
			end
			OP_SUB_FIRST, OP_MASK_FIRST: begin
				legal = 1'b1;
				cycles = CYC_SHORT;
			end
			default: begin
				legal = ((pwdata[7:0] > OP_SUB_FIRST) &&
					(pwdata[7:0] <= OP_SUB_LAST)) ||
					((pwdata[7:0] > OP_MASK_FIRST) &&
					(pwdata[7:0] <= OP_MASK_LAST));
				cycles = CYC_LONG;
			end
		endcase
	end

	assign start = wr_ctrl && pwdata[CTRL_GO_BIT] && legal;
	assign done = (state_reg == ST_EXEC) && (cnt_reg == 3'h0);

	// Sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 3'h0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (start) begin
						state_reg <= ST_EXEC;
						cnt_reg <= cycles - 3'h1;
					end
				end
				ST_EXEC: begin
					if (cnt_reg != 3'h0) begin
						cnt_reg <= cnt_reg - 3'h1;
					end else if (op_reg == OP_STOP) begin
						state_reg <= ST_STOP; // see [RULE4]
					end else begin
						state_reg <= ST_IDLE;
					end
				end
				ST_STOP: begin
					// Only the external interrupt or reset leaves stop
					if (!int_n_sync) begin
						state_reg <= ST_IDLE; // see [RULE6]
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Opcode latch and illegal-opcode status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_reg <= OP_RST;
			err_reg <= 1'b0;
		end else if (wr_ctrl && pwdata[CTRL_GO_BIT]) begin
			err_reg <= !legal;
			if (legal) begin
				op_reg <= pwdata[7:0];
			end
		end
	end

	// Datapath
	assign sub_sum = {1'b0, dst_reg} + {1'b0, ~src_reg} +
		9'h001; // see [RULE8]
	assign nib_sum = {1'b0, dst_reg[3:0]} + {1'b0, ~src_reg[3:0]} + 5'h01;

	always_comb begin
		res = dst_reg;
		flags_next = flags_reg;
		dst_wr = 1'b0;
		if (op_reg == OP_SET_CARRY) begin
			flags_next[FLAG_C] = 1'b1; // see [RULE1]
		end else if (is_shift) begin
			res = {dst_reg[7], dst_reg[7:1]}; // see [RULE2]
			dst_wr = 1'b1;
			flags_next[FLAG_C] = dst_reg[0]; // see [RULE3]
			flags_next[FLAG_Z] = (res == 8'h00);
			flags_next[FLAG_S] = res[7];
			flags_next[FLAG_V] = 1'b0;
		end else if (is_sub) begin
			res = sub_sum[7:0]; // see [RULE8]
			dst_wr = 1'b1;
			flags_next[FLAG_C] = !sub_sum[8]; // see [RULE9]
			flags_next[FLAG_Z] = (res == 8'h00);
			flags_next[FLAG_S] = res[7];
			flags_next[FLAG_V] = (dst_reg[7] != src_reg[7]) &&
				(res[7] == src_reg[7]);
			flags_next[FLAG_D] = 1'b1; // see [RULE10]
			flags_next[FLAG_H] = !nib_sum[4];
		end else if (is_mask) begin
			res = ~dst_reg & src_reg; // see [RULE11]
			flags_next[FLAG_Z] = (res == 8'h00); // see [RULE12]
			flags_next[FLAG_S] = res[7];
			flags_next[FLAG_V] = 1'b0;
		end
	end

	// Destination operand: result committed only at completion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dst_reg <= DST_RST;
		end else if (done && dst_wr) begin
			dst_reg <= res; // see [RULE13]
		end else if (apb_wr && idle && paddr == OFS_DST) begin
			dst_reg <= pwdata[7:0];
		end
	end

	// Source operand is never written by execution
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_reg <= SRC_RST;
		end else if (apb_wr && idle && paddr == OFS_SRC) begin
			src_reg <= pwdata[7:0]; // see [RULE8]
		end
	end

	// Flags committed in the same edge as the result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_reg <= FLAGS_RST;
		end else if (done) begin
			flags_reg <= flags_next; // see [RULE13]
		end else if (apb_wr && idle && paddr == OFS_FLAGS) begin
			flags_reg <= pwdata[7:0] & FLAGS_MASK;
		end
	end

	// Read data registered in the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				OFS_CTRL: prdata <= {24'h00_0000, op_reg};
				OFS_DST: prdata <= {24'h00_0000, dst_reg};
				OFS_SRC: prdata <= {24'h00_0000, src_reg};
				OFS_FLAGS: prdata <= {24'h00_0000, flags_reg};
				OFS_STATUS: begin
					prdata <= 32'h0000_0000;
					prdata[STAT_BUSY_BIT] <= (state_reg == ST_EXEC);
					prdata[STAT_STOP_BIT] <= (state_reg == ST_STOP);
					prdata[STAT_ERR_BIT] <= err_reg;
				end
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Clock control: both clocks gated while stopped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_mode <= 1'b0;
			cpu_clk_en <= 1'b1;
			sys_clk_en <= 1'b1;
		end else begin
			stop_mode <= (state_reg == ST_STOP); // see [RULE4]
			cpu_clk_en <= (state_reg != ST_STOP);
			sys_clk_en <= (state_reg != ST_STOP);
		end
	end

	a_set_carry_flags: assert property ( // see [RULE1]
		done && op_reg == OP_SET_CARRY |=> flags_reg[FLAG_C] &&
		flags_reg[6:0] == $past(flags_reg[6:0]))
		else $error("set carry flag update wrong");

	a_set_carry_length: assert property ( // see [RULE1]
		start && pwdata[7:0] == OP_SET_CARRY |=>
		(state_reg == ST_EXEC)[*4] ##1 (state_reg == ST_IDLE))
		else $error("set carry did not take four cycles");

	a_shift_result: assert property ( // see [RULE2]
		done && is_shift |=> dst_reg ==
		{$past(dst_reg[7]), $past(dst_reg[7:1])})
		else $error("arithmetic shift result wrong");

	a_shift_flags: assert property ( // see [RULE3]
		done && is_shift |=> flags_reg[FLAG_C] == $past(dst_reg[0]) &&
		!flags_reg[FLAG_V] && flags_reg[FLAG_S] == dst_reg[7] &&
		flags_reg[FLAG_Z] == (dst_reg == 8'h00) &&
		flags_reg[3:2] == $past(flags_reg[3:2]))
		else $error("arithmetic shift flags wrong");

	a_stop_enter: assert property ( // see [RULE4]
		done && op_reg == OP_STOP |=> flags_reg == $past(flags_reg)
		##1 stop_mode && !cpu_clk_en && !sys_clk_en)
		else $error("stop did not gate clocks");

	a_stop_retain: assert property ( // see [RULE5]
		state_reg == ST_STOP |=> $stable(dst_reg) &&
		$stable(src_reg) && $stable(flags_reg))
		else $error("state changed during stop");

	a_stop_exit: assert property ( // see [RULE6]
		state_reg == ST_STOP && int_n_sync |=> state_reg == ST_STOP)
		else $error("stop left without wake-up");

	a_stop_wake: assert property ( // see [RULE6]
		state_reg == ST_STOP && !int_n_sync |=> state_reg == ST_IDLE)
		else $error("wake-up did not leave stop");

	a_sub_result: assert property ( // see [RULE8]
		done && is_sub |=> dst_reg ==
		8'($past(dst_reg) - $past(src_reg)) && $stable(src_reg))
		else $error("subtract result wrong");

	a_sub_flags: assert property ( // see [RULE9]
		done && is_sub |=> flags_reg[FLAG_C] ==
		($past(dst_reg) < $past(src_reg)) &&
		flags_reg[FLAG_Z] == (dst_reg == 8'h00) &&
		flags_reg[FLAG_S] == dst_reg[7])
		else $error("subtract flags wrong");

	a_sub_dh: assert property ( // see [RULE10]
		done && is_sub |=> flags_reg[FLAG_D] && flags_reg[FLAG_H] ==
		($past(dst_reg[3:0]) < $past(src_reg[3:0])))
		else $error("subtract D or H wrong");

	a_mask_flags: assert property ( // see [RULE12]
		done && is_mask |=> $stable(dst_reg) && !flags_reg[FLAG_V] &&
		flags_reg[FLAG_Z] == (($past(~dst_reg) & src_reg) == 8'h00) &&
		flags_reg[FLAG_C] == $past(flags_reg[FLAG_C]))
		else $error("mask test flags wrong");

	a_mask_operands: assert property ( // see [RULE11]
		done && is_mask |=> $stable(dst_reg) && $stable(src_reg) &&
		flags_reg[FLAG_S] == $past(~dst_reg[7] & src_reg[7]))
		else $error("mask test changed an operand");

	a_commit_together: assert property ( // see [RULE13]
		done |=> flags_reg == $past(flags_next) &&
		dst_reg == ($past(dst_wr) ? $past(res) : $past(dst_reg)))
		else $error("result and flags not committed together");

	a_refuse_busy: assert property ( // see [RULE5]
		acc && pwrite && !idle |-> pslverr)
		else $error("write accepted while busy or stopped");

endmodule

// ===== verilog/alu_pkg.sv
package alu_pkg;

	// Register byte offsets on the APB bus
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DST = 8'h04;
	localparam logic [7:0] OFS_SRC = 8'h08;
	localparam logic [7:0] OFS_FLAGS = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// Control register fields
	localparam int CTRL_GO_BIT = 8;

	// Flag bit positions within the flags register
	localparam int FLAG_C = 7;
	localparam int FLAG_Z = 6;
	localparam int FLAG_S = 5;
	localparam int FLAG_V = 4;
	localparam int FLAG_D = 3;
	localparam int FLAG_H = 2;
	localparam logic [7:0] FLAGS_MASK = 8'hFC;

	// Status register fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_STOP_BIT = 1;
	localparam int STAT_ERR_BIT = 2;

	// Values after reset
	localparam logic [7:0] DST_RST = 8'h00;
	localparam logic [7:0] SRC_RST = 8'h00;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] OP_RST = 8'h00;
	localparam logic EXT_INT_N_RST = 1'b1;

	// Opcodes handled by this datapath
	localparam logic [7:0] OP_SET_CARRY = 8'hDF;
	localparam logic [7:0] OP_SHIFT_R = 8'hD0;
	localparam logic [7:0] OP_SHIFT_IR = 8'hD1;
	localparam logic [7:0] OP_STOP = 8'h7F;
	localparam logic [7:0] OP_SUB_FIRST = 8'h22;
	localparam logic [7:0] OP_SUB_LAST = 8'h26;
	localparam logic [7:0] OP_MASK_FIRST = 8'h62;
	localparam logic [7:0] OP_MASK_LAST = 8'h66;

	// Execution lengths in cycles
	localparam logic [2:0] CYC_SHORT = 3'h4;
	localparam logic [2:0] CYC_LONG = 3'h6;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXEC,
		ST_STOP
	} alu_state_t;

endpackage

// ===== verilog/alu_sync2.sv
`timescale 1ns/100ps

module alu_sync2 #(
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Asynchronous level in, synchronised level out
	input wire logic async_in,
	output logic sync_out
);

	logic meta_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule

// ===== verification/alu_core_test.sv
`timescale 1ns/100ps

module alu_core_test;
	import alu_pkg::*;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic ext_int_n = 1'h1;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, cpu_clk_en, sys_clk_en, stop_mode;
	logic [32:0] exp_q[$];
	logic [7:0] ops[13] = '{8'hDF, 8'hD0, 8'hD1, 8'h22, 8'h23, 8'h24,
		8'h25, 8'h26, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66};
	logic [7:0] nd, nf, fl;
	int error_cnt = 0;
	int samples_checked = 0;
	int wait_n;

	always #25 pclk = ~pclk;

	alu_core alu_core_i(.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_int_n(ext_int_n),
		.cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
		.stop_mode(stop_mode));

	task summarize;
		$display("checked %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task chk(input logic [32:0] seen, input logic [32:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Completed accesses are matched against the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'h1) begin
			if (exp_q.size() == 0) begin
				chk({pslverr, prdata}, 33'h1FFFFFFFF);
			end else begin
				chk({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
			end
		end
	end

	// Leaves psel high so a back-to-back setup can follow
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e);
		int n;
		n = 0;
		exp_q.push_back(e);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		if (n == 20) begin
			error_cnt++;
			summarize;
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'h1, a, d, 33'h0);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'h0, a, 32'h0, {1'h0, e});
	endtask

	task cyc(input int n);
		psel <= 1'h0;
		penable <= 1'h0;
		repeat (n) @(posedge pclk);
	endtask

	task calc(input logic [7:0] op, d, s, f);
		logic [7:0] r;
		nd = d;
		nf = f;
		r = d;
		if (op == OP_SET_CARRY) begin
			nf[FLAG_C] = 1'h1;
		end else if (op == OP_SHIFT_R || op == OP_SHIFT_IR) begin
			r = {d[7], d[7:1]};
			nd = r;
			nf[FLAG_C] = d[0];
			nf[FLAG_V] = 1'h0;
		end else if (op <= OP_SUB_LAST) begin
			r = d - s;
			nd = r;
			nf[FLAG_C] = d < s;
			nf[FLAG_V] = (d[7] != s[7]) && (r[7] == s[7]);
			nf[FLAG_D] = 1'h1;
			nf[FLAG_H] = d[3:0] < s[3:0];
		end else begin
			r = ~d & s;
			nf[FLAG_V] = 1'h0;
		end
		if (op != OP_SET_CARRY) begin
			nf[FLAG_Z] = r == 8'h00;
			nf[FLAG_S] = r[7];
		end
	endtask

	task run(input logic [7:0] op, d, s);
		logic lng;
		lng = (op[7:4] == 4'h2 || op[7:4] == 4'h6) &&
			op != OP_SUB_FIRST && op != OP_MASK_FIRST;
		fl = 8'($urandom) & FLAGS_MASK;
		calc(op, d, s, fl);
		wr(OFS_DST, {24'h0, d});
		wr(OFS_SRC, {24'h0, s});
		wr(OFS_FLAGS, {24'h0, fl});
		wr(OFS_CTRL, {23'h0, 1'h1, op});
		xfer(1'h1, OFS_DST, 32'h0, {1'h1, 32'h0});
		rd(OFS_STATUS, 32'h1);
		rd(OFS_STATUS, {31'h0, lng});
		cyc(8);
		rd(OFS_DST, {24'h0, nd});
		rd(OFS_SRC, {24'h0, s});
		rd(OFS_FLAGS, {24'h0, nf});
		rd(OFS_STATUS, 32'h0);
		rd(OFS_CTRL, {24'h0, op});
		cyc(1);
	endtask

	task stop_now(input logic [7:0] d);
		wr(OFS_DST, {24'h0, d});
		wr(OFS_FLAGS, {24'h0, fl});
		wr(OFS_CTRL, {23'h0, 1'h1, OP_STOP});
		cyc(10);
		chk({stop_mode, cpu_clk_en, sys_clk_en}, 33'h4);
	endtask

	initial begin
		void'($urandom(32'h9B015011));
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		chk({stop_mode, cpu_clk_en, sys_clk_en}, 33'h3);
		rd(OFS_DST, {24'h0, DST_RST});
		rd(OFS_FLAGS, {24'h0, FLAGS_RST});
		rd(OFS_STATUS, 32'h0);
		cyc(1);
		$display("reset values done");
		run(8'h22, 8'h12, 8'h03);
		run(8'h24, 8'h21, 8'h90);
		run(8'h26, 8'h21, 8'h65);
		run(8'hD0, 8'h9A, 8'h00);
		run(8'hD1, 8'hBC, 8'h00);
		run(8'h62, 8'hC7, 8'h02);
		run(8'h66, 8'h2B, 8'h34);
		foreach (ops[i]) run(ops[i], 8'($urandom), 8'($urandom));
		repeat (40) run(ops[$urandom % 13], 8'($urandom), 8'($urandom));
		$display("opcode tests done");
		xfer(1'h0, 8'h14, 32'h0, {1'h1, 32'h0});
		xfer(1'h1, OFS_STATUS, 32'h7, {1'h1, 32'h0});
		wr(OFS_CTRL, 32'h101);
		cyc(3);
		rd(OFS_STATUS, 32'h4);
		cyc(1);
		run(8'h64, 8'h00, 8'h00);
		$display("refusal tests done");
		stop_now(8'h5A);
		xfer(1'h1, OFS_DST, 32'h11, {1'h1, 32'h0});
		rd(OFS_STATUS, 32'h2);
		rd(OFS_DST, 32'h5A);
		rd(OFS_FLAGS, {24'h0, fl});
		cyc(4);
		chk({31'h0, stop_mode}, 33'h1);
		ext_int_n <= 1'h0;
		wait_n = 0;
		while (stop_mode !== 1'h0 && wait_n < 20) begin
			wait_n++;
			@(posedge pclk);
		end
		if (wait_n == 20) begin
			error_cnt++;
			summarize;
		end
		ext_int_n <= 1'h1;
		chk({stop_mode, cpu_clk_en, sys_clk_en}, 33'h3);
		@(posedge pclk);
		rd(OFS_STATUS, 32'h0);
		cyc(1);
		$display("interrupt wake done");
		stop_now(8'hA5);
		presetn <= 1'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		chk({stop_mode, cpu_clk_en, sys_clk_en}, 33'h3);
		rd(OFS_DST, {24'h0, DST_RST});
		cyc(2);
		$display("reset wake done");
		summarize;
	end

	initial begin
		#1000000;
		error_cnt++;
		summarize;
	end
endmodule
